// File: inc/cab_map.vh
`ifndef CAB_MAP_VH
`define CAB_MAP_VH
// ****************
// Operation codes
// ****************
`define CAB_OP_BYTE_SUM 6'h00
`define CAB_OP_BYTE_SUM_CARRY 6'h01
`define CAB_OP_WORD_SUM_IMMEDIATE 6'h02
`define CAB_OP_BYTE_MINUS 6'h03
`define CAB_OP_MINUS_IMMEDIATE 6'h04
`define CAB_OP_MINUS_WITH_BORROW 6'h05
`define CAB_OP_MINUS_IMMEDIATE_BORROW 6'h06
`define CAB_OP_WORD_MINUS_IMMEDIATE 6'h07
`define CAB_OP_CONJ 6'h08
`define CAB_OP_CONJ_IMMEDIATE 6'h09
`define CAB_OP_DISJ 6'h0a
`define CAB_OP_DISJ_IMMEDIATE 6'h0b
`define CAB_OP_EXCLUSIVE_DISJ 6'h0c
`define CAB_OP_BITWISE_INVERT 6'h0d
`define CAB_OP_ARITH_INVERT 6'h0e
`define CAB_OP_MASK_SET_BITS 6'h0f
`define CAB_OP_MASK_CLEAR_BITS 6'h10
`define CAB_OP_PLUS_ONE 6'h11
`define CAB_OP_MINUS_ONE 6'h12
`define CAB_OP_ZERO_SIGN_TEST 6'h13
`define CAB_OP_ZERO_REGISTER 6'h14
`define CAB_OP_ALL_ONES_LOAD 6'h15
`define CAB_OP_PRODUCT_UNSIGNED 6'h16
`define CAB_OP_PRODUCT_SIGNED 6'h17
`define CAB_OP_PRODUCT_MIXED 6'h18
`define CAB_OP_FRAC_PRODUCT_UNSIGNED 6'h19
`define CAB_OP_FRAC_PRODUCT_SIGNED 6'h1a
`define CAB_OP_FRAC_PRODUCT_MIXED 6'h1b
`define CAB_OP_RELATIVE_JUMP 6'h1c
`define CAB_OP_POINTER_JUMP 6'h1d
`define CAB_OP_DIRECT_GOTO 6'h1e
`define CAB_OP_RELATIVE_CALL 6'h1f
`define CAB_OP_POINTER_CALL 6'h20
`define CAB_OP_DIRECT_CALL 6'h21
`define CAB_OP_STACK_POP_BRANCH 6'h22
`define CAB_OP_INTERRUPT_EXIT 6'h23
`define CAB_OP_EQUAL_SKIP 6'h24
`define CAB_OP_COMPARE_REGS 6'h25
`define CAB_OP_COMPARE_WITH_CARRY_IN 6'h26
`define CAB_OP_COMPARE_IMMEDIATE 6'h27
`define CAB_OP_BIT_CLEAR_SKIP 6'h28
`define CAB_OP_BIT_SET_SKIP 6'h29
// ****************
// Status flag positions
// ****************
`define CAB_FLAG_C 0
`define CAB_FLAG_Z 1
`define CAB_FLAG_N 2
`define CAB_FLAG_V 3
`define CAB_FLAG_S 4
`define CAB_FLAG_H 5
`define CAB_FLAG_T 6
`define CAB_FLAG_I 7
// ****************
// Reset values, register indices, cycle counts
// ****************
`define CAB_SREG_RST 8'h00
`define CAB_PC_RST 16'h0000
`define CAB_REG_R0 5'h00
`define CAB_REG_R1 5'h01
`define CAB_REG_ZLO 5'h1e
`define CAB_REG_ZHI 5'h1f
`define CAB_CYC_ONE 3'h1
`define CAB_CYC_TWO 3'h2
`define CAB_CYC_THREE 3'h3
`define CAB_CYC_FOUR 3'h4
`endif

// File: verilog/cab_core.v
`timescale 1ns/1ps
`include "cab_map.vh"

module cab_core (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Operation request
  input wire op_valid,
  input wire [5:0] op_code,
  input wire [4:0] op_dst,
  input wire [4:0] op_src,
  input wire [7:0] op_imm,
  input wire [2:0] op_bit,
  input wire [11:0] op_offset,
  input wire [15:0] op_target,
  input wire next_long,
  output wire op_ready,
  output reg op_done,
  // Program flow state
  output reg [15:0] pc,
  output reg [7:0] sreg,
  // Return stack
  output reg stack_push,
  output reg [15:0] stack_push_addr,
  output wire stack_pop,
  input wire [15:0] stack_pop_addr,
  // Register file load and peek
  input wire load_en,
  input wire [4:0] load_addr,
  input wire [7:0] load_data,
  input wire [4:0] peek_addr,
  output reg [7:0] peek_data
);

  // ****************
  // Helpers
  // ****************
  localparam ST_IDLE = 2'b01;
  localparam ST_STALL = 2'b10;

  // Returns {carry, half carry, overflow, result}
  function [10:0] arith8;
    input sub;
    input cin;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] full;
    reg [4:0] nib;
    reg v;
    begin
      if (sub) begin
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
      end else begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        v = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
      end
      arith8 = {full[8], nib[4], v, full[7:0]};
    end
  endfunction

  // Sets N, V, S and Z from a byte result
  function [7:0] nvsz;
    input [7:0] s;
    input [7:0] res;
    input v;
    begin
      nvsz = s;
      nvsz[`CAB_FLAG_N] = res[7];
      nvsz[`CAB_FLAG_V] = v;
      nvsz[`CAB_FLAG_S] = res[7] ^ v;
      nvsz[`CAB_FLAG_Z] = (res == 8'h00);
    end
  endfunction

  // ****************
  // State
  // ****************
  reg [7:0] rf_q [0:31];
  reg [1:0] state_q;
  reg [2:0] cnt_q;
  integer i;

  // ****************
  // Operation decode and datapath
  // ****************
  reg [7:0] rd_v;
  reg [7:0] rr_v;
  reg [10:0] ar;
  reg [15:0] word_v;
  reg [15:0] word_r;
  reg signed [8:0] ma;
  reg signed [8:0] mb;
  reg signed [17:0] mp;
  reg [15:0] prod;
  reg [7:0] sreg_d;
  reg [15:0] pc_d;
  reg [2:0] cyc_d;
  reg we_a;
  reg [4:0] wa_a;
  reg [7:0] wd_a;
  reg we_b;
  reg [4:0] wa_b;
  reg [7:0] wd_b;
  reg push_d;
  reg [15:0] push_addr_d;
  reg pop_d;
  reg skip;
  reg [15:0] pc_next;
  reg [15:0] pc_rel;
  reg [15:0] z_ptr;

  wire take = op_valid & op_ready;

  assign op_ready = state_q[0];
  assign stack_pop = take & pop_d;

  always @* begin
    rd_v = rf_q[op_dst];
    rr_v = rf_q[op_src];
    ar = 11'h000;
    word_v = {rf_q[op_dst | 5'h01], rf_q[op_dst]};
    word_r = 16'h0000;
    ma = 9'h000;
    mb = 9'h000;
    mp = 18'h0_0000;
    prod = 16'h0000;
    sreg_d = sreg;
    pc_next = pc + 16'h0001;
    pc_rel = pc + {{4{op_offset[11]}}, op_offset} + 16'h0001;
    z_ptr = {rf_q[`CAB_REG_ZHI], rf_q[`CAB_REG_ZLO]};
    pc_d = pc_next;
    cyc_d = `CAB_CYC_ONE;
    we_a = 1'b0;
    wa_a = op_dst;
    wd_a = 8'h00;
    we_b = 1'b0;
    wa_b = op_dst | 5'h01;
    wd_b = 8'h00;
    push_d = 1'b0;
    push_addr_d = pc_next;
    pop_d = 1'b0;
    skip = 1'b0;
    case (op_code)
      `CAB_OP_BYTE_SUM, `CAB_OP_BYTE_SUM_CARRY: begin
        ar = arith8(1'b0, (op_code == `CAB_OP_BYTE_SUM_CARRY) & sreg[`CAB_FLAG_C],
          rd_v, rr_v);
        we_a = 1'b1;
        wd_a = ar[7:0];
        sreg_d = nvsz(sreg, ar[7:0], ar[8]);
        sreg_d[`CAB_FLAG_C] = ar[10];
        sreg_d[`CAB_FLAG_H] = ar[9];
      end
      `CAB_OP_BYTE_MINUS, `CAB_OP_MINUS_IMMEDIATE, `CAB_OP_MINUS_WITH_BORROW,
      `CAB_OP_MINUS_IMMEDIATE_BORROW, `CAB_OP_ARITH_INVERT, `CAB_OP_COMPARE_REGS,
      `CAB_OP_COMPARE_WITH_CARRY_IN, `CAB_OP_COMPARE_IMMEDIATE: begin
        if (op_code == `CAB_OP_ARITH_INVERT) begin
          ar = arith8(1'b1, 1'b0, 8'h00, rd_v);
        end else if (op_code == `CAB_OP_MINUS_IMMEDIATE ||
                     op_code == `CAB_OP_COMPARE_IMMEDIATE) begin
          ar = arith8(1'b1, 1'b0, rd_v, op_imm);
        end else if (op_code == `CAB_OP_MINUS_IMMEDIATE_BORROW) begin
          ar = arith8(1'b1, sreg[`CAB_FLAG_C], rd_v, op_imm);
        end else if (op_code == `CAB_OP_MINUS_WITH_BORROW ||
                     op_code == `CAB_OP_COMPARE_WITH_CARRY_IN) begin
          ar = arith8(1'b1, sreg[`CAB_FLAG_C], rd_v, rr_v);
        end else begin
          ar = arith8(1'b1, 1'b0, rd_v, rr_v);
        end
        // Compares leave the destination alone
        we_a = (op_code != `CAB_OP_COMPARE_REGS) &&
               (op_code != `CAB_OP_COMPARE_WITH_CARRY_IN) &&
               (op_code != `CAB_OP_COMPARE_IMMEDIATE);
        wd_a = ar[7:0];
        sreg_d = nvsz(sreg, ar[7:0], ar[8]);
        sreg_d[`CAB_FLAG_C] = ar[10];
        sreg_d[`CAB_FLAG_H] = ar[9];
        // Borrow chains keep Z only while every byte so far was zero
        if (op_code == `CAB_OP_MINUS_WITH_BORROW || op_code == `CAB_OP_MINUS_IMMEDIATE_BORROW ||
            op_code == `CAB_OP_COMPARE_WITH_CARRY_IN) begin
          sreg_d[`CAB_FLAG_Z] = (ar[7:0] == 8'h00) & sreg[`CAB_FLAG_Z];
        end
      end
      `CAB_OP_WORD_SUM_IMMEDIATE, `CAB_OP_WORD_MINUS_IMMEDIATE: begin
        if (op_code == `CAB_OP_WORD_SUM_IMMEDIATE) begin
          word_r = word_v + {10'h000, op_imm[5:0]};
          sreg_d[`CAB_FLAG_V] = ~word_v[15] & word_r[15];
          sreg_d[`CAB_FLAG_C] = word_v[15] & ~word_r[15];
        end else begin
          word_r = word_v - {10'h000, op_imm[5:0]};
          sreg_d[`CAB_FLAG_V] = word_v[15] & ~word_r[15];
          sreg_d[`CAB_FLAG_C] = ~word_v[15] & word_r[15];
        end
        sreg_d[`CAB_FLAG_N] = word_r[15];
        sreg_d[`CAB_FLAG_S] = word_r[15] ^ sreg_d[`CAB_FLAG_V];
        sreg_d[`CAB_FLAG_Z] = (word_r == 16'h0000);
        we_a = 1'b1;
        wd_a = word_r[7:0];
        we_b = 1'b1;
        wd_b = word_r[15:8];
        cyc_d = `CAB_CYC_TWO;
      end
      `CAB_OP_CONJ, `CAB_OP_CONJ_IMMEDIATE, `CAB_OP_DISJ, `CAB_OP_DISJ_IMMEDIATE,
      `CAB_OP_EXCLUSIVE_DISJ, `CAB_OP_MASK_SET_BITS, `CAB_OP_MASK_CLEAR_BITS,
      `CAB_OP_ZERO_SIGN_TEST, `CAB_OP_ZERO_REGISTER: begin
        case (op_code)
          `CAB_OP_CONJ: wd_a = rd_v & rr_v;
          `CAB_OP_CONJ_IMMEDIATE: wd_a = rd_v & op_imm;
          `CAB_OP_DISJ: wd_a = rd_v | rr_v;
          `CAB_OP_DISJ_IMMEDIATE: wd_a = rd_v | op_imm;
          `CAB_OP_EXCLUSIVE_DISJ: wd_a = rd_v ^ rr_v;
          `CAB_OP_MASK_SET_BITS: wd_a = rd_v | op_imm;
          `CAB_OP_MASK_CLEAR_BITS: wd_a = rd_v & (8'hff - op_imm);
          `CAB_OP_ZERO_SIGN_TEST: wd_a = rd_v & rd_v;
          default: wd_a = rd_v ^ rd_v;
        endcase
        // Carry and half carry are not touched
        we_a = 1'b1;
        sreg_d = nvsz(sreg, wd_a, 1'b0);
      end
      `CAB_OP_BITWISE_INVERT: begin
        we_a = 1'b1;
        wd_a = 8'hff - rd_v;
        sreg_d = nvsz(sreg, wd_a, 1'b0);
        sreg_d[`CAB_FLAG_C] = 1'b1;
      end
      `CAB_OP_PLUS_ONE, `CAB_OP_MINUS_ONE: begin
        we_a = 1'b1;
        if (op_code == `CAB_OP_PLUS_ONE) begin
          wd_a = rd_v + 8'h01;
          sreg_d = nvsz(sreg, wd_a, wd_a == 8'h80);
        end else begin
          wd_a = rd_v - 8'h01;
          sreg_d = nvsz(sreg, wd_a, wd_a == 8'h7f);
        end
      end
      `CAB_OP_ALL_ONES_LOAD: begin
        we_a = 1'b1;
        wd_a = 8'hff;
      end
      `CAB_OP_PRODUCT_UNSIGNED, `CAB_OP_PRODUCT_SIGNED, `CAB_OP_PRODUCT_MIXED,
      `CAB_OP_FRAC_PRODUCT_UNSIGNED, `CAB_OP_FRAC_PRODUCT_SIGNED,
      `CAB_OP_FRAC_PRODUCT_MIXED: begin
        // Sign-extend per operand so one signed multiplier serves all six
        ma = (op_code == `CAB_OP_PRODUCT_UNSIGNED || op_code == `CAB_OP_FRAC_PRODUCT_UNSIGNED) ?
          {1'b0, rd_v} : {rd_v[7], rd_v};
        mb = (op_code == `CAB_OP_PRODUCT_SIGNED || op_code == `CAB_OP_FRAC_PRODUCT_SIGNED) ?
          {rr_v[7], rr_v} : {1'b0, rr_v};
        mp = ma * mb;
        prod = mp[15:0];
        sreg_d[`CAB_FLAG_C] = prod[15];
        if (op_code == `CAB_OP_FRAC_PRODUCT_UNSIGNED || op_code == `CAB_OP_FRAC_PRODUCT_SIGNED ||
            op_code == `CAB_OP_FRAC_PRODUCT_MIXED) begin
          prod = {prod[14:0], 1'b0};
        end
        sreg_d[`CAB_FLAG_Z] = (prod == 16'h0000);
        we_a = 1'b1;
        wa_a = `CAB_REG_R0;
        wd_a = prod[7:0];
        we_b = 1'b1;
        wa_b = `CAB_REG_R1;
        wd_b = prod[15:8];
        cyc_d = `CAB_CYC_TWO;
      end
      `CAB_OP_RELATIVE_JUMP: begin
        pc_d = pc_rel;
        cyc_d = `CAB_CYC_TWO;
      end
      `CAB_OP_POINTER_JUMP: begin
        pc_d = z_ptr;
        cyc_d = `CAB_CYC_TWO;
      end
      `CAB_OP_DIRECT_GOTO: begin
        pc_d = op_target;
        cyc_d = `CAB_CYC_THREE;
      end
      `CAB_OP_RELATIVE_CALL: begin
        push_d = 1'b1;
        pc_d = pc_rel;
        cyc_d = `CAB_CYC_THREE;
      end
      `CAB_OP_POINTER_CALL: begin
        push_d = 1'b1;
        pc_d = z_ptr;
        cyc_d = `CAB_CYC_THREE;
      end
      `CAB_OP_DIRECT_CALL: begin
        // Two-word instruction returns past its target word
        push_d = 1'b1;
        push_addr_d = pc + 16'h0002;
        pc_d = op_target;
        cyc_d = `CAB_CYC_FOUR;
      end
      `CAB_OP_STACK_POP_BRANCH, `CAB_OP_INTERRUPT_EXIT: begin
        pop_d = 1'b1;
        pc_d = stack_pop_addr;
        cyc_d = `CAB_CYC_FOUR;
        if (op_code == `CAB_OP_INTERRUPT_EXIT) begin
          sreg_d[`CAB_FLAG_I] = 1'b1;
        end
      end
      `CAB_OP_EQUAL_SKIP, `CAB_OP_BIT_CLEAR_SKIP, `CAB_OP_BIT_SET_SKIP: begin
        if (op_code == `CAB_OP_EQUAL_SKIP) begin
          skip = (rd_v == rr_v);
        end else begin
          skip = rr_v[op_bit] == (op_code == `CAB_OP_BIT_SET_SKIP);
        end
        if (skip) begin
          pc_d = pc + (next_long ? 16'h0003 : 16'h0002);
          cyc_d = next_long ? `CAB_CYC_THREE : `CAB_CYC_TWO;
        end
      end
      default: begin
        cyc_d = `CAB_CYC_ONE;
      end
    endcase
  end

  // ****************
  // Sequencing and commit
  // ****************
  // Results land at the issue edge; the core then refuses new work
  // for the remaining cycles so the count seen outside is exact.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      op_done <= 1'b0;
      pc <= `CAB_PC_RST;
      sreg <= `CAB_SREG_RST;
      stack_push <= 1'b0;
      stack_push_addr <= 16'h0000;
      peek_data <= 8'h00;
      for (i = 0; i < 32; i = i + 1) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      peek_data <= rf_q[peek_addr];
      stack_push <= take & push_d;
      op_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            pc <= pc_d;
            sreg <= sreg_d;
            if (push_d) begin
              stack_push_addr <= push_addr_d;
            end
            if (cyc_d == `CAB_CYC_ONE) begin
              op_done <= 1'b1;
            end else begin
              state_q <= ST_STALL;
              cnt_q <= cyc_d - 3'h1;
            end
          end
        end
        ST_STALL: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= ST_IDLE;
            op_done <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Load port yields to an operation writing the same cycle
      if (load_en && !(take && (we_a || we_b))) begin
        rf_q[load_addr] <= load_data;
      end
      if (take && we_a) begin
        rf_q[wa_a] <= wd_a;
      end
      if (take && we_b) begin
        rf_q[wa_b] <= wd_b;
      end
    end
  end

endmodule

// File: test/cab_core_sva.sv
`timescale 1ns/1ps
`include "cab_map.vh"

module cab_core_sva (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Operation port
  input wire op_valid,
  input wire [5:0] op_code,
  input wire [11:0] op_offset,
  input wire [15:0] op_target,
  input wire op_ready,
  input wire op_done,
  // Flow state and stack
  input wire [15:0] pc,
  input wire [7:0] sreg,
  input wire stack_push,
  input wire [15:0] stack_push_addr,
  input wire stack_pop,
  input wire [15:0] stack_pop_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire take = op_valid && op_ready;
  // Relative forms land one past the signed offset
  wire [15:0] rel_step = {{4{op_offset[11]}}, op_offset} + 16'h0001;

  // ****************
  // Properties
  // ****************
  AST_SUM_ONE: assert property (
    take && op_code == `CAB_OP_BYTE_SUM |=> op_done && op_ready)
    else $error("byte sum not done in one cycle");
  AST_WORD_TWO: assert property (
    take && op_code inside {`CAB_OP_WORD_SUM_IMMEDIATE, `CAB_OP_WORD_MINUS_IMMEDIATE}
    |=> !op_ready ##1 op_done)
    else $error("word op not done in two cycles");
  AST_LOGIC_KEEP: assert property (
    take && op_code inside {[`CAB_OP_CONJ:`CAB_OP_EXCLUSIVE_DISJ]}
    |=> op_done && (sreg & 8'h21) == ($past(sreg) & 8'h21))
    else $error("logic op touched carry flags");
  AST_STEP_KEEP_C: assert property (
    take && op_code inside {`CAB_OP_PLUS_ONE, `CAB_OP_MINUS_ONE}
    |=> op_done && (sreg & 8'h01) == ($past(sreg) & 8'h01))
    else $error("step op touched carry");
  AST_PRODUCT_TWO: assert property (
    take && op_code inside {[`CAB_OP_PRODUCT_UNSIGNED:`CAB_OP_FRAC_PRODUCT_MIXED]}
    |=> !op_ready ##1 op_done)
    else $error("product not done in two cycles");
  AST_PTR_JUMP: assert property (
    take && op_code == `CAB_OP_POINTER_JUMP |=> sreg == $past(sreg) && !op_ready ##1 op_done)
    else $error("pointer jump timing or flags wrong");
  AST_PTR_CALL: assert property (
    take && op_code == `CAB_OP_POINTER_CALL |=> stack_push &&
    stack_push_addr == $past(pc) + 16'h0001 ##1 !op_ready ##1 op_done)
    else $error("pointer call push or timing wrong");
  AST_REL_JUMP: assert property (
    take && op_code == `CAB_OP_RELATIVE_JUMP
    |=> !op_ready && pc == $past(pc) + $past(rel_step) ##1 op_done)
    else $error("relative jump target or timing wrong");
  AST_DIRECT_CALL: assert property (
    take && op_code == `CAB_OP_DIRECT_CALL
    |=> (pc == $past(op_target) && stack_push && !op_ready) ##1 (!op_ready) [*2] ##1 op_done)
    else $error("direct call target or timing wrong");
  AST_RETURN_POP: assert property (
    take && op_code inside {`CAB_OP_STACK_POP_BRANCH, `CAB_OP_INTERRUPT_EXIT}
    |-> stack_pop ##1 pc == $past(stack_pop_addr) ##3 op_done)
    else $error("return pop or timing wrong");
  AST_EXIT_SETS_I: assert property (
    take && op_code == `CAB_OP_INTERRUPT_EXIT |=> sreg[`CAB_FLAG_I])
    else $error("interrupt exit left enable clear");
  AST_ONES_FLAGLESS: assert property (
    take && op_code == `CAB_OP_ALL_ONES_LOAD |=> op_done && sreg == $past(sreg))
    else $error("all ones load changed flags");
  AST_SKIP_FLAGS: assert property (
    take && op_code inside {`CAB_OP_EQUAL_SKIP, `CAB_OP_BIT_CLEAR_SKIP, `CAB_OP_BIT_SET_SKIP}
    |=> sreg == $past(sreg))
    else $error("skip changed flags");
endmodule

bind cab_core cab_core_sva sva_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_offset(op_offset), .op_target(op_target), .op_ready(op_ready),
  .op_done(op_done), .pc(pc), .sreg(sreg), .stack_push(stack_push),
  .stack_push_addr(stack_push_addr), .stack_pop(stack_pop), .stack_pop_addr(stack_pop_addr));

// File: test/cab_core_bench.sv
`timescale 1ns/1ps
`include "cab_map.vh"

module cab_core_bench;
  reg sys_clk = '0;
  reg sys_rst = 1'h1;
  reg op_valid = '0, next_long = '0, load_en = '0;
  reg [5:0] op_code = '0;
  reg [4:0] op_dst = '0, op_src = '0, load_addr = '0, peek_addr = '0;
  reg [7:0] op_imm = '0, load_data = '0, v, w;
  reg [2:0] op_bit = '0;
  reg [11:0] op_offset = '0;
  reg [15:0] op_target = '0, stack_pop_addr = 16'h0abc, p;
  wire op_ready, op_done, stack_push, stack_pop;
  wire [15:0] pc, stack_push_addr;
  wire [7:0] sreg, peek_data;
  int failures = 0, checks = 0, ncyc, i;
  // Rows: op, dst value, src value or constant, carry in, result, flags
  reg [47:0] rows [0:22] = '{48'h007f_0100_802c, 48'h01ff_0001_0023, 48'h0310_0100_0f20,
    48'h0400_0100_ff35, 48'h0580_0001_7f38, 48'h0601_0100_0002, 48'h08f0_3c01_3021,
    48'h090f_f000_0002, 48'h0a80_0101_8135, 48'h0b00_0000_0002, 48'h0caa_aa01_0023,
    48'h0d0f_0000_f015, 48'h0e01_0000_ff35, 48'h0f01_8001_8135, 48'h10ff_0f00_f014,
    48'h117f_0001_802d, 48'h1280_0000_7f18, 48'h1380_0001_8035, 48'h145a_0001_0023,
    48'h1512_0001_ff35, 48'h2510_2000_1015, 48'h2620_1f01_2020, 48'h2780_0100_8038};
  // Skips: op, dst, src, bit, long, pc step
  reg [39:0] skips [0:6] = '{40'h24_5555_0002, 40'h24_5555_0103, 40'h24_5556_0101,
    40'h28_00fd_1002, 40'h28_0002_1101, 40'h29_0080_7103, 40'h29_007f_7001};
  reg [15:0] prods [0:5] = '{16'h01fe, 16'hfffe, 16'hfffe, 16'h03fc, 16'hfffc, 16'hfffc};
  reg [5:0] prod_c = 6'h36;

  always #5 sys_clk = ~sys_clk;

  cab_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .op_dst(op_dst), .op_src(op_src), .op_imm(op_imm), .op_bit(op_bit), .op_offset(op_offset),
    .op_target(op_target), .next_long(next_long), .op_ready(op_ready), .op_done(op_done),
    .pc(pc), .sreg(sreg), .stack_push(stack_push), .stack_push_addr(stack_push_addr),
    .stack_pop(stack_pop), .stack_pop_addr(stack_pop_addr), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr), .peek_data(peek_data));

  // ****************
  // Driver and compare tasks
  // ****************
  task automatic chk(input string what, input [15:0] seen, input [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Hold above one edge to offer a request while the core is busy
  task automatic issue(input [5:0] c, input [4:0] d, input [4:0] s, input [7:0] k, input int hold);
    @(posedge sys_clk);
    op_valid <= 1'h1;
    op_code <= c;
    op_dst <= d;
    op_src <= s;
    op_imm <= k;
    repeat (hold) @(posedge sys_clk);
    op_valid <= 1'h0;
    #1;
    ncyc = 1;
    while (op_done !== 1'b1 && ncyc < 8) begin
      @(posedge sys_clk);
      #1;
      ncyc++;
    end
  endtask

  task automatic load(input [4:0] a, input [7:0] d);
    @(posedge sys_clk);
    load_en <= 1'h1;
    load_addr <= a;
    load_data <= d;
    @(posedge sys_clk);
    load_en <= 1'h0;
  endtask

  task automatic peek(input [4:0] a, output [7:0] d);
    @(posedge sys_clk);
    peek_addr <= a;
    @(posedge sys_clk);
    #1;
    d = peek_data;
  endtask

  task automatic flow(input [5:0] c, input [11:0] off, input [15:0] tgt, input [15:0] epc,
    input [15:0] en);
    @(posedge sys_clk);
    op_offset <= off;
    op_target <= tgt;
    issue(c, 5'h00, 5'h00, 8'h00, 1);
    chk("pc", pc, epc);
    chk("cycles", 16'(ncyc), en);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    wrap_up;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    #1;
    chk("pc", pc, 16'h0000);
    chk("sreg", 16'(sreg), 16'h0000);
    chk("ready", 16'(op_ready), 16'h0001);
    for (i = 0; i < 23; i++) begin
      load(5'h10, rows[i][39:32]);
      load(5'h11, rows[i][31:24]);
      issue(`CAB_OP_COMPARE_IMMEDIATE, 5'h14, 5'h00, rows[i][23:16], 1);
      issue(rows[i][45:40], 5'h10, 5'h11, rows[i][31:24], 1);
      chk("cycles", 16'(ncyc), 16'h0001);
      chk("sreg", 16'(sreg), 16'(rows[i][7:0]));
      peek(5'h10, v);
      chk("result", 16'(v), 16'(rows[i][15:8]));
    end
    load(5'h18, 8'hff);
    load(5'h19, 8'hff);
    issue(`CAB_OP_WORD_SUM_IMMEDIATE, 5'h18, 5'h00, 8'h01, 1);
    chk("cycles", 16'(ncyc), 16'h0002);
    chk("word flags", 16'(sreg[4:0]), 16'h0003);
    issue(`CAB_OP_WORD_MINUS_IMMEDIATE, 5'h18, 5'h00, 8'h3f, 1);
    chk("word flags", 16'(sreg[4:0]), 16'h0015);
    peek(5'h18, v);
    peek(5'h19, w);
    chk("word", {w, v}, 16'hffc1);
    load(5'h10, 8'hff);
    load(5'h11, 8'h02);
    for (i = 0; i < 6; i++) begin
      issue(`CAB_OP_PRODUCT_UNSIGNED + i[5:0], 5'h10, 5'h11, 8'h00, 1);
      chk("cycles", 16'(ncyc), 16'h0002);
      chk("zc", 16'(sreg[1:0]), 16'(prod_c[i]));
      peek(5'h00, v);
      peek(5'h01, w);
      chk("product", {w, v}, prods[i]);
    end
    // Second edge of the held request lands while busy
    p = pc;
    issue(`CAB_OP_PRODUCT_UNSIGNED, 5'h10, 5'h11, 8'h00, 2);
    chk("refused pc", pc, p + 16'h0001);
    load(5'h10, 8'h7e);
    p = pc;
    issue(`CAB_OP_PLUS_ONE, 5'h10, 5'h00, 8'h00, 2);
    chk("pc", pc, p + 16'h0002);
    peek(5'h10, v);
    chk("back to back", 16'(v), 16'h0080);
    load(5'h1e, 8'h78);
    load(5'h1f, 8'h56);
    p = pc;
    flow(`CAB_OP_RELATIVE_JUMP, 12'h005, 16'h0000, p + 16'h0006, 16'h0002);
    p = pc;
    flow(`CAB_OP_RELATIVE_JUMP, 12'hffe, 16'h0000, p - 16'h0001, 16'h0002);
    flow(`CAB_OP_DIRECT_GOTO, 12'h000, 16'h1234, 16'h1234, 16'h0003);
    flow(`CAB_OP_POINTER_JUMP, 12'h000, 16'h0000, 16'h5678, 16'h0002);
    p = pc;
    flow(`CAB_OP_RELATIVE_CALL, 12'h003, 16'h0000, p + 16'h0004, 16'h0003);
    chk("push", stack_push_addr, p + 16'h0001);
    p = pc;
    flow(`CAB_OP_POINTER_CALL, 12'h000, 16'h0000, 16'h5678, 16'h0003);
    chk("push", stack_push_addr, p + 16'h0001);
    p = pc;
    flow(`CAB_OP_DIRECT_CALL, 12'h000, 16'h2000, 16'h2000, 16'h0004);
    chk("push", stack_push_addr, p + 16'h0002);
    flow(`CAB_OP_STACK_POP_BRANCH, 12'h000, 16'h0000, 16'h0abc, 16'h0004);
    flow(`CAB_OP_INTERRUPT_EXIT, 12'h000, 16'h0000, 16'h0abc, 16'h0004);
    chk("int enable", 16'(sreg[7]), 16'h0001);
    for (i = 0; i < 7; i++) begin
      load(5'h10, skips[i][31:24]);
      load(5'h11, skips[i][23:16]);
      @(posedge sys_clk);
      op_bit <= skips[i][14:12];
      next_long <= skips[i][8];
      p = pc;
      issue(skips[i][37:32], 5'h10, 5'h11, 8'h00, 1);
      chk("skip pc", pc - p, 16'(skips[i][7:0]));
      chk("cycles", 16'(ncyc), 16'(skips[i][7:0]));
    end
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    #1;
    chk("pc", pc, 16'h0000);
    chk("sreg", 16'(sreg), 16'h0000);
    peek(5'h1e, v);
    chk("reg", 16'(v), 16'h0000);
    wrap_up;
  end
endmodule
